// [hw/cif_map.vh]
// Constants for the current input channel filter.
`ifndef CIF_MAP_VH
`define CIF_MAP_VH
`define CIF_IDX_HI          8'h24
`define CIF_IDX_LO_OFFSET   8'h00
`define CIF_IDX_LO_MAXCNT   8'h01
`define CIF_IDX_LO_AVG      8'h02
`define CIF_LEN_WORD        8'h02
`define CIF_LEN_BYTE        8'h01
`define CIF_RST_OFFSET      16'h0000
`define CIF_RST_MAXCNT      16'h7d00
`define CIF_RST_AVG         8'h01
`define CIF_AVG_MAX         8'h50
`define CIF_FULL_SCALE      16'h7d00
`define CIF_STAT_FAULT_BIT  0
`endif

// [hw/cif_avg.v]
// Moving-average filter for one channel with a window of 1 to MAX_N samples.
`timescale 1ns/10ps
module cif_avg #(
    parameter MAX_N = 80
) (
    input  wire               i_mclk,
    input  wire               i_rst_n,
    input  wire [7:0]         i_avg_n,
    input  wire               i_restart,
    input  wire               i_smp_vld,
    input  wire signed [15:0] i_smp,
    output reg                o_vld,
    output reg  signed [15:0] o_mean
);
    reg signed [15:0] hist_q [0:MAX_N-1];
    reg        [6:0]  wr_q;
    reg        [7:0]  fill_q;
    reg signed [23:0] sum_q;
    reg signed [23:0] sum_d;
    reg        [7:0]  fill_d;
    reg signed [15:0] old_w;
    reg signed [23:0] quo_w;

    // The running sum drops the oldest sample only once the window is full.
    always @* begin
        old_w  = hist_q[wr_q];
        fill_d = (fill_q == i_avg_n) ? fill_q : fill_q + 8'h01;
        sum_d  = sum_q + {{8{i_smp[15]}}, i_smp};
        if (fill_q == i_avg_n) begin
            sum_d = sum_d - {{8{old_w[15]}}, old_w};
        end
        quo_w  = sum_d / $signed({16'h0000, fill_d}); // The window is never empty here.
    end

    // A restart empties the history; stale words are never read before refill.
    always @(posedge i_mclk) begin
        if (!i_rst_n || i_restart) begin
            wr_q   <= 7'h00;
            fill_q <= 8'h00;
            sum_q  <= 24'sh000000;
            o_vld  <= 1'b0;
            o_mean <= 16'sh0000;
        end else begin
            o_vld <= i_smp_vld;
            if (i_smp_vld) begin
                hist_q[wr_q] <= i_smp;
                wr_q   <= (wr_q + 7'h01 >= i_avg_n[6:0]) ? 7'h00 : wr_q + 7'h01;
                fill_q <= fill_d;
                sum_q  <= sum_d;
                o_mean <= quo_w[15:0];
            end
        end
    end
endmodule

// [hw/cif_top.v]
// Four-channel calibration, averaging and enable logic for a current input module.
`timescale 1ns/10ps
`include "cif_map.vh"
module cif_top #(
    parameter NCH   = 4,
    parameter MAX_N = 80
) (
    input  wire         i_mclk,
    input  wire         i_rst_n,
    input  wire         i_req_vld,
    input  wire [7:0]   i_req_len,
    input  wire [7:0]   i_req_idx_lo,
    input  wire [7:0]   i_req_idx_hi,
    input  wire [7:0]   i_req_sub,
    input  wire [15:0]  i_req_data,
    input  wire         i_cfg_download,
    input  wire         i_auto_cfg,
    input  wire [3:0]   i_ch_en_wr,
    input  wire [3:0]   i_ch_en,
    input  wire [3:0]   i_conv_vld,
    input  wire [63:0]  i_conv_raw,
    input  wire [31:0]  i_conv_stat,
    output reg          o_req_ack,
    output reg          o_req_err,
    output reg  [3:0]   o_ch_en,
    output reg  [63:0]  o_ch_data,
    output reg  [31:0]  o_ch_stat,
    output reg  [3:0]   o_data_vld,
    output reg          o_fault_led
);
    // Staged values written by requests, and the live values used by the datapath.
    reg [15:0] stg_off_q [0:3];
    reg [15:0] stg_max_q [0:3];
    reg [15:0] off_q     [0:3];
    reg [15:0] max_q     [0:3];
    reg [7:0]  avg_q     [0:3];
    reg [3:0]  restart_q;
    wire [3:0]  flt_vld;
    wire [63:0] flt_mean;
    reg  [63:0] cal_w;
    reg  [1:0]  req_ch_w;
    reg         hit_off_w;
    reg         hit_max_w;
    reg         hit_avg_w;
    reg         avg_new_w;
    integer     k;
    integer     kc;
    integer     ko;

    // Sub-index 1..4 maps to channel 0..3; anything else is refused.
    function sub_ok;
        input [7:0] sub;
        begin
            sub_ok = (sub >= 8'h01) && (sub <= 8'h04);
        end
    endfunction

    // Sub-index 1..4 becomes channel 0..3; the wrap of 0 - 1 to 3 for sub-index 4 is intended.
    function [1:0] ch_idx;
        input [7:0] sub;
        begin
            ch_idx = sub[1:0] - 2'h1;
        end
    endfunction

    // Linear two-point calibration: offset maps to 0, max count maps to full scale.
    function [15:0] calib;
        input [15:0] raw;
        input [15:0] off;
        input [15:0] mx;
        reg signed [33:0] num;
        reg signed [17:0] den;
        reg signed [33:0] quo;
        begin
            den = $signed({{2{mx[15]}}, mx}) - $signed({{2{off[15]}}, off});
            num = ($signed({{18{raw[15]}}, raw}) - $signed({{18{off[15]}}, off}))
                  * $signed({18'h00000, `CIF_FULL_SCALE});
            if (den == 18'sh00000) begin
                calib = raw;
            end else begin
                quo   = num / den;
                calib = quo[15:0];
            end
        end
    endfunction

    // Any enabled channel with its summary fault bit set lights the indicator.
    function fault_any;
        input [31:0] stat;
        input [3:0]  en;
        integer      n;
        begin
            fault_any = 1'b0;
            for (n = 0; n < 4; n = n + 1) begin
                fault_any = fault_any | (en[n] & stat[8*n + `CIF_STAT_FAULT_BIT]);
            end
        end
    endfunction

    // Request decode; a request that hits none of the three entries is refused.
    always @* begin
        req_ch_w  = ch_idx(i_req_sub);
        hit_off_w = 1'b0;
        hit_max_w = 1'b0;
        hit_avg_w = 1'b0;
        if (i_req_idx_hi == `CIF_IDX_HI && sub_ok(i_req_sub)) begin
            hit_off_w = (i_req_idx_lo == `CIF_IDX_LO_OFFSET) && (i_req_len == `CIF_LEN_WORD);
            hit_max_w = (i_req_idx_lo == `CIF_IDX_LO_MAXCNT) && (i_req_len == `CIF_LEN_WORD);
            hit_avg_w = (i_req_idx_lo == `CIF_IDX_LO_AVG) && (i_req_len == `CIF_LEN_BYTE) &&
                        (i_req_data[7:0] >= 8'h01) && (i_req_data[7:0] <= `CIF_AVG_MAX);
        end
        // Rewriting the count already in use leaves the history intact.
        avg_new_w = hit_avg_w && (avg_q[req_ch_w] != i_req_data[7:0]);
    end

    // Parameter requests land in staging or, for averaging, straight in the live byte.
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            for (k = 0; k < 4; k = k + 1) begin
                stg_off_q[k] <= `CIF_RST_OFFSET;
                stg_max_q[k] <= `CIF_RST_MAXCNT;
                off_q[k]     <= `CIF_RST_OFFSET;
                max_q[k]     <= `CIF_RST_MAXCNT;
                avg_q[k]     <= `CIF_RST_AVG;
            end
            restart_q <= 4'h0;
            o_req_ack <= 1'b0;
            o_req_err <= 1'b0;
        end else begin
            restart_q <= 4'h0;
            o_req_ack <= i_req_vld;
            o_req_err <= 1'b0;
            if (i_req_vld) begin
                if (hit_off_w) begin
                    stg_off_q[req_ch_w] <= i_req_data;
                end else if (hit_max_w) begin
                    stg_max_q[req_ch_w] <= i_req_data;
                end else if (hit_avg_w) begin
                    avg_q[req_ch_w]     <= i_req_data[7:0];
                    restart_q[req_ch_w] <= avg_new_w;
                end else begin
                    o_req_err <= 1'b1;
                end
            end
            // Calibration goes live only when the whole configuration is downloaded.
            if (i_cfg_download) begin
                for (k = 0; k < 4; k = k + 1) begin
                    off_q[k] <= stg_off_q[k];
                    max_q[k] <= stg_max_q[k];
                end
            end
        end
    end

    // Channel enables; automatic configuration turns every channel on.
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_ch_en <= 4'hf;
        end else if (i_auto_cfg) begin
            o_ch_en <= 4'hf;
        end else begin
            o_ch_en <= (o_ch_en & ~i_ch_en_wr) | (i_ch_en & i_ch_en_wr);
        end
    end

    // A disabled channel is fed count zero, the count for minimum current.
    always @* begin
        cal_w = 64'h0;
        for (kc = 0; kc < NCH; kc = kc + 1) begin
            if (o_ch_en[kc]) begin
                cal_w[16*kc +: 16] = calib(i_conv_raw[16*kc +: 16], off_q[kc], max_q[kc]);
            end else begin
                cal_w[16*kc +: 16] = 16'h0000;
            end
        end
    end

    // One independent filter per channel; a count change restarts that channel's filter and empties its history.
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            cif_avg #(
                .MAX_N     (MAX_N)
            ) u_avg (
                .i_mclk    (i_mclk),
                .i_rst_n   (i_rst_n),
                .i_avg_n   (avg_q[g]),
                .i_restart (restart_q[g]),
                .i_smp_vld (i_conv_vld[g]),
                .i_smp     (cal_w[16*g +: 16]),
                .o_vld     (flt_vld[g]),
                .o_mean    (flt_mean[16*g +: 16])
            );
        end
    endgenerate

    // Output stage; disabled channels are forced to zero data and zero status.
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_ch_data   <= 64'h0;
            o_ch_stat   <= 32'h0;
            o_data_vld  <= 4'h0;
            o_fault_led <= 1'b0;
        end else begin
            o_data_vld  <= flt_vld & o_ch_en;
            o_fault_led <= fault_any(i_conv_stat, o_ch_en);
            // Status follows the converter at once; data waits for the filter's valid.
            for (ko = 0; ko < NCH; ko = ko + 1) begin
                if (!o_ch_en[ko]) begin
                    o_ch_data[16*ko +: 16] <= 16'h0000;
                    o_ch_stat[8*ko +: 8]   <= 8'h00;
                end else begin
                    if (flt_vld[ko]) begin
                        o_ch_data[16*ko +: 16] <= flt_mean[16*ko +: 16];
                    end
                    o_ch_stat[8*ko +: 8] <= i_conv_stat[8*ko +: 8];
                end
            end
        end
    end
endmodule

// [testbench/cif_top_sva.sv]
// Port assertions for the current input channel filter.
`timescale 1ns/10ps
module cif_top_sva (
    input wire        i_mclk,
    input wire        i_rst_n,
    input wire        i_req_vld,
    input wire [7:0]  i_req_idx_lo,
    input wire [7:0]  i_req_idx_hi,
    input wire [15:0] i_req_data,
    input wire        i_auto_cfg,
    input wire [3:0]  i_ch_en_wr,
    input wire        o_req_ack,
    input wire        o_req_err,
    input wire [3:0]  o_ch_en,
    input wire [63:0] o_ch_data,
    input wire [31:0] o_ch_stat,
    input wire [3:0]  o_data_vld,
    input wire        o_fault_led
);
    // One clock domain, so every check shares the clock and rests in reset.
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // Request answers come exactly one cycle after the request.
    AST_ACK: assert property (i_req_vld |=> o_req_ack)
        else $error("request not answered");
    AST_NOACK: assert property (!i_req_vld |=> !o_req_ack)
        else $error("answer without request");
    AST_ERRACK: assert property (o_req_err |-> o_req_ack)
        else $error("refusal outside an answer");
    AST_BADHI: assert property (i_req_vld && i_req_idx_hi != 8'h24 |=> o_req_err)
        else $error("foreign index accepted");
    AST_AVGRNG: assert property (i_req_vld && i_req_idx_lo == 8'h02 &&
        (i_req_data[7:0] == 8'h00 || i_req_data[7:0] > 8'h50) |=> o_req_err)
        else $error("averaging count out of range accepted");
    AST_AUTO: assert property (i_auto_cfg && i_ch_en_wr == 4'h0 |=> o_ch_en == 4'hf)
        else $error("auto configuration left a channel off");
    // Two cycles of grace cover samples already in the pipeline.
    AST_DIS: assert property (!o_ch_en[3] && !$past(o_ch_en[3]) && !$past(o_ch_en[3], 2)
        |-> o_ch_data[63:48] == 16'h0000 && o_ch_stat[31:24] == 8'h00 && !o_data_vld[3])
        else $error("disabled channel shows data");
    AST_LED: assert property (o_ch_en == 4'h0 && $past(o_ch_en) == 4'h0 |-> !o_fault_led)
        else $error("fault indicator lit with all channels off");
    AST_VLDEN: assert property ((o_data_vld & ~$past(o_ch_en)) == 4'h0)
        else $error("new data flagged on a disabled channel");
endmodule
bind cif_top cif_top_sva i_sva (.i_mclk, .i_rst_n, .i_req_vld, .i_req_idx_lo, .i_req_idx_hi,
    .i_req_data, .i_auto_cfg, .i_ch_en_wr, .o_req_ack, .o_req_err, .o_ch_en, .o_ch_data,
    .o_ch_stat, .o_data_vld, .o_fault_led);

// [testbench/cif_gw_model.sv]
// Behavioural island gateway model that issues parameter requests.
`timescale 1ns/10ps
module cif_gw_model (
    input  wire        i_mclk,
    input  wire        i_ack,
    input  wire        i_err,
    output reg         o_vld,
    output reg  [47:0] o_req
);
    // Idle at time zero with no request pending.
    initial begin
        o_vld = 1'b0;
        o_req = 48'h0;
    end
    // The answer is read mid-cycle while it stands and handed back for judging.
    task put(input [47:0] req, output logic ack, output logic err);
        @(negedge i_mclk);
        o_vld = 1'b1;
        o_req = req;
        @(negedge i_mclk);
        ack = i_ack;
        err = i_err;
        o_vld = 1'b0;
        o_req = ~req;
    endtask
endmodule

// [testbench/tb_cif_top.sv]
// Self-checking bench for the current input channel filter.
`timescale 1ns/10ps
module tb_cif_top;
    reg         mclk = 1'b0;
    reg         rst_n = 1'b0;
    reg         dl = 1'b0;
    reg         auto = 1'b0;
    reg  [3:0]  en_wr = 4'h0;
    reg  [3:0]  en = 4'h0;
    reg  [3:0]  cvld = 4'h0;
    reg  [63:0] craw = 64'h0;
    reg  [31:0] cstat = 32'h0;
    reg  [3:0]  en_exp = 4'hf;
    wire        vld, ack, rerr, led;
    wire [47:0] rq;
    wire [3:0]  ch_en, dvld;
    wire [63:0] dat;
    wire [31:0] stat;
    integer     err_total = 0;
    integer     checked = 0;
    integer     i;
    logic       a, e;
    // Free-running clock and both ends of the request path.
    always #10 mclk = ~mclk;
    cif_top i_dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_req_vld(vld), .i_req_len(rq[47:40]),
        .i_req_idx_lo(rq[39:32]), .i_req_idx_hi(rq[31:24]), .i_req_sub(rq[23:16]),
        .i_req_data(rq[15:0]), .i_cfg_download(dl), .i_auto_cfg(auto), .i_ch_en_wr(en_wr),
        .i_ch_en(en), .i_conv_vld(cvld), .i_conv_raw(craw), .i_conv_stat(cstat),
        .o_req_ack(ack), .o_req_err(rerr), .o_ch_en(ch_en), .o_ch_data(dat), .o_ch_stat(stat),
        .o_data_vld(dvld), .o_fault_led(led));
    cif_gw_model i_gw (.i_mclk(mclk), .i_ack(ack), .i_err(rerr), .o_vld(vld), .o_req(rq));
    task check(input [15:0] seen, input [15:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task req(input [47:0] r, input x);
        i_gw.put(r, a, e);
        check(a, 1'b1);
        check(e, x);
    endtask
    // One conversion; output is read after its fixed two-cycle pipeline.
    task samp(input integer ch, input [15:0] v, input [7:0] s);
        @(negedge mclk);
        cvld[ch] = 1'b1;
        craw[16*ch+:16] = v;
        cstat[8*ch+:8] = s;
        @(negedge mclk);
        cvld = 4'h0;
        @(negedge mclk);
        check(dvld[ch], en_exp[ch]);
        @(negedge mclk);
        check(dvld[ch], 1'b0);
    endtask
    task t_pass;
        check(ch_en, 4'hf);
        samp(0, 16'h03e8, 8'h00);
        check(dat[15:0], 16'h03e8);
        samp(0, 16'h7d00, 8'h00);
        check(dat[15:0], 16'h7d00);
        $display("t_pass done");
    endtask
    task t_avg;
        req(48'h01_02_24_02_0004, 1'b0);
        for (i = 1; i < 5; i = i + 1) samp(1, 16'h0064 * i, 8'h00);
        check(dat[31:16], 16'h00fa);
        samp(0, 16'h0007, 8'h00);
        check(dat[15:0], 16'h0007);
        check(dat[31:16], 16'h00fa);
        req(48'h01_02_24_02_0008, 1'b0);
        samp(1, 16'h000a, 8'h00);
        samp(1, 16'h0014, 8'h00);
        check(dat[31:16], 16'h000f);
        $display("t_avg done");
    endtask
    task t_refuse;
        req(48'h01_02_24_01_0000, 1'b1);
        req(48'h01_02_24_01_0051, 1'b1);
        req(48'h01_02_25_01_0004, 1'b1);
        req(48'h01_02_24_00_0004, 1'b1);
        req(48'h01_02_24_05_0004, 1'b1);
        req(48'h02_02_24_01_0004, 1'b1);
        req(48'h01_02_24_01_0050, 1'b0);
        $display("t_refuse done");
    endtask
    task t_cal;
        req(48'h02_00_24_03_0064, 1'b0);
        req(48'h02_01_24_03_7d64, 1'b0);
        samp(2, 16'h7d64, 8'h00);
        check(dat[47:32], 16'h7d64);
        @(negedge mclk) dl = 1'b1;
        @(negedge mclk) dl = 1'b0;
        samp(2, 16'h7d64, 8'h00);
        check(dat[47:32], 16'h7d00);
        samp(2, 16'h3ee4, 8'h00);
        check(dat[47:32], 16'h3e80);
        samp(2, 16'h0064, 8'h00);
        check(dat[47:32], 16'h0000);
        $display("t_cal done");
    endtask
    // Faulty status on a switched-off channel must stay hidden.
    task t_dis;
        @(negedge mclk) en_wr = 4'hf;
        @(negedge mclk) en_wr = 4'h0;
        en_exp = 4'h0;
        samp(3, 16'h1234, 8'h01);
        check(ch_en, 4'h0);
        check(dat[63:48], 16'h0000);
        check(stat[31:24], 8'h00);
        check(led, 1'b0);
        @(negedge mclk) auto = 1'b1;
        @(negedge mclk) auto = 1'b0;
        en_exp = 4'hf;
        check(ch_en, 4'hf);
        samp(3, 16'h1234, 8'h01);
        check(led, 1'b1);
        check(dat[63:48], 16'h1234);
        check(stat[31:24], 8'h01);
        $display("t_dis done");
    endtask
    // A reset in mid-run brings back the one-sample window and the uncalibrated path.
    task t_rst;
        @(negedge mclk) rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        check(dat[31:16], 16'h0000);
        samp(1, 16'h0050, 8'h00);
        samp(1, 16'h0010, 8'h00);
        check(dat[31:16], 16'h0010);
        samp(2, 16'h7d64, 8'h00);
        check(dat[47:32], 16'h7d64);
        $display("t_rst done");
    endtask
    task stop_test;
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Main sequence after eight cycles of reset.
    initial begin
        repeat (8) @(negedge mclk);
        rst_n = 1'b1;
        t_pass;
        t_avg;
        t_refuse;
        t_cal;
        t_dis;
        t_rst;
        stop_test;
    end
    // A hang is cut short and counted as a failure.
    initial begin
        repeat (5000) @(posedge mclk);
        err_total = err_total + 1;
        stop_test;
    end
endmodule
